// File: core/isl_sleep_entry.sv
`timescale 1ns/1ps
// Function
// - acknowledge the final sleep identifier byte 86h
// - stop driving the data line after the ninth rising clock edge
// - start sleep at ninth rising edge, release data line 8 cycles later, one cycle before asleep rises
// - release while clock high shows as a stray STOP on the bus
// - after wake, wait 1 to 400 us before normal access is ready
module isl_sleep_entry #(
  parameter int REC_CYC = isl_pkg::REC_MAX_CYC,
  parameter int PU_CYC = isl_pkg::PU_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sleep_armed,
  output logic sda_o,
  output logic sda_oe,
  output logic asleep,
  output logic ready,
  output logic stray_stop
);
  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  isl_pkg::isl_pins_t pins_raw;
  isl_pkg::isl_pins_t pins_s;
  isl_pkg::isl_pins_t pins_prev_q;
  isl_pkg::isl_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [isl_pkg::CNT_W-1:0] cnt_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic id_match;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign pins_raw = '{scl: scl_i, sda: sda_i};

  isl_sync #(.W(2), .RST_VAL(isl_pkg::PINS_RST)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(pins_raw),
    .dout(pins_s)
  );

  // ****************************************
  // bus event detection
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_q <= isl_pkg::PINS_RST;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  assign scl_rise = pins_s.scl && !pins_prev_q.scl;
  assign scl_fall = !pins_s.scl && pins_prev_q.scl;
  assign start_det = pins_s.scl && pins_prev_q.scl && !pins_s.sda && pins_prev_q.sda;
  assign stop_det = pins_s.scl && pins_prev_q.scl && pins_s.sda && !pins_prev_q.sda;
  assign id_match = (shift_q == isl_pkg::SLEEP_ID) && sleep_armed;

  // ****************************************
  // byte shifter
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else if (start_det) begin
      bit_cnt_q <= 4'h0;
    end else if (state_q == isl_pkg::ST_SHIFT && scl_rise && bit_cnt_q < isl_pkg::ACK_BIT) begin
      shift_q <= {shift_q[6:0], pins_s.sda};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= isl_pkg::ST_PWRUP;
      cnt_q <= '0;
    end else begin
      case (state_q)
        isl_pkg::ST_PWRUP: begin
          if (cnt_q == isl_pkg::CNT_W'(PU_CYC - 1)) begin
            state_q <= isl_pkg::ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        isl_pkg::ST_IDLE: begin
          if (start_det) begin
            state_q <= isl_pkg::ST_SHIFT;
          end
        end
        isl_pkg::ST_SHIFT: begin
          if (stop_det) begin
            state_q <= isl_pkg::ST_IDLE;
          end else if (scl_fall && bit_cnt_q == isl_pkg::ACK_BIT) begin
            state_q <= id_match ? isl_pkg::ST_ACK : isl_pkg::ST_IDLE;
          end
        end
        isl_pkg::ST_ACK: begin
          if (scl_rise) begin
            state_q <= isl_pkg::ST_ENTER;
            cnt_q <= '0;
          end
        end
        isl_pkg::ST_ENTER: begin
          if (cnt_q == isl_pkg::CNT_W'(isl_pkg::SETTLE_CYC - 1)) begin
            state_q <= isl_pkg::ST_SLEEP;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        isl_pkg::ST_SLEEP: begin
          if (start_det) begin
            state_q <= isl_pkg::ST_RECOVER;
            cnt_q <= '0;
          end
        end
        isl_pkg::ST_RECOVER: begin
          if (cnt_q == isl_pkg::CNT_W'(REC_CYC - 1)) begin
            state_q <= isl_pkg::ST_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= isl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // output flops
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      if (state_q == isl_pkg::ST_SHIFT && scl_fall && bit_cnt_q == isl_pkg::ACK_BIT) begin
        sda_oe <= id_match;
      end else if (state_q == isl_pkg::ST_ENTER
                   && cnt_q == isl_pkg::CNT_W'(isl_pkg::SETTLE_CYC - 1)) begin
        sda_oe <= 1'b0;
      end else if (state_q != isl_pkg::ST_ACK && state_q != isl_pkg::ST_ENTER) begin
        sda_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      asleep <= 1'b0;
      ready <= 1'b0;
      stray_stop <= 1'b0;
    end else begin
      asleep <= (state_q == isl_pkg::ST_SLEEP);
      ready <= (state_q == isl_pkg::ST_IDLE || state_q == isl_pkg::ST_SHIFT);
      stray_stop <= stop_det
                    && (state_q == isl_pkg::ST_ENTER || state_q == isl_pkg::ST_SLEEP);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_ack_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(sda_oe) |-> $past(shift_q) == isl_pkg::SLEEP_ID && state_q == isl_pkg::ST_ACK)
    else $error("ack driven for a byte other than the sleep id");

  a_ack_given: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == isl_pkg::ST_SHIFT && scl_fall && bit_cnt_q == isl_pkg::ACK_BIT && id_match
    |=> sda_oe && !sda_o)
    else $error("sleep id not acknowledged");

  a_ack_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == isl_pkg::ST_ACK && $past(state_q) == isl_pkg::ST_ACK |-> sda_oe)
    else $error("ack released before ninth rising edge");

  a_entry_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == isl_pkg::ST_ACK && scl_rise |=> state_q == isl_pkg::ST_ENTER)
    else $error("sleep entry not begun at ninth rising edge");

  a_release_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(state_q == isl_pkg::ST_ENTER) |-> sda_oe [*8] ##1 !sda_oe && asleep == 1'b0)
    else $error("data line not released on sleep entry");

  a_asleep_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
    asleep |-> !sda_oe)
    else $error("data line driven while asleep");

  a_stray_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stop_det && state_q == isl_pkg::ST_SLEEP |=> stray_stop)
    else $error("stop during sleep entry not flagged");

  a_rec_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == isl_pkg::ST_RECOVER |-> !ready)
    else $error("ready during sleep recovery");

  a_wake_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == isl_pkg::ST_SLEEP && start_det |=> state_q == isl_pkg::ST_RECOVER ##1 !ready)
    else $error("wake did not begin recovery");
endmodule : isl_sleep_entry

// File: common/isl_pkg.sv
package isl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_MHZ = 250;
  localparam int REC_MIN_US = 1;
  localparam int REC_MAX_US = 400;
  localparam int PU_US = 250;
  localparam int REC_MIN_CYC = REC_MIN_US * SYS_MHZ;
  localparam int REC_MAX_CYC = REC_MAX_US * SYS_MHZ;
  localparam int PU_CYC = PU_US * SYS_MHZ;
  localparam int SETTLE_CYC = 8;
  localparam int CNT_W = 17;

  // ****************************************
  // protocol values
  // ****************************************
  localparam logic [7:0] SLEEP_ID = 8'h86;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PINS_RST = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic scl;
    logic sda;
  } isl_pins_t;

  typedef enum logic [2:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_SHIFT,
    ST_ACK,
    ST_ENTER,
    ST_SLEEP,
    ST_RECOVER
  } isl_state_t;

endpackage : isl_pkg

// File: core/isl_sync.sv
`timescale 1ns/1ps
module isl_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : isl_sync

// File: tb/isl_master_model.sv
`timescale 1ns/1ps
// ********
// bus master model
// ********
module isl_master_model (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  localparam int H = 10;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hw
  task automatic start_c();
    sda_oe <= 1'b0;
    hw(H);
    scl <= 1'b1;
    hw(H);
    sda_oe <= 1'b1;
    hw(H);
  endtask : start_c
  task automatic stop_c();
    scl <= 1'b0;
    sda_oe <= 1'b1;
    hw(H);
    scl <= 1'b1;
    hw(H);
    sda_oe <= 1'b0;
    hw(H);
  endtask : stop_c
  // a stray stop while floating does not wake the device; it only raises stray_stop
  task automatic send_byte(input logic [7:0] b, input logic hold_low, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      scl <= 1'b0;
      hw(H);
      sda_oe <= !b[i];
      hw(H);
      scl <= 1'b1;
      hw(H);
    end
    scl <= 1'b0;
    hw(1);
    sda_oe <= 1'b0;
    hw(H);
    scl <= 1'b1;
    hw(1);
    ack = (sda === 1'b0);
    sda_oe <= hold_low;
    hw(2 * H);
    scl <= 1'b0;
    hw(H);
  endtask : send_byte
endmodule : isl_master_model

// File: tb/isl_sleep_entry_test.sv
`timescale 1ns/1ps
// ********
// bench top
// ********
module isl_sleep_entry_test;
  logic clk_sys, rst_b, armed, scl, m_oe, ack, sda_o, sda_oe, asleep, ready, stray_stop;
  wire sda_w;
  int fails, samples_checked, strays, n;
  assign sda_w = !(m_oe || sda_oe);
  isl_sleep_entry #(.REC_CYC(300), .PU_CYC(20)) isl_sleep_entry_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .scl_i(scl), .sda_i(sda_w), .sleep_armed(armed), .sda_o(sda_o),
    .sda_oe(sda_oe), .asleep(asleep), .ready(ready), .stray_stop(stray_stop));
  isl_master_model isl_master_model_inst (.clk_sys(clk_sys), .sda(sda_w), .scl(scl),
    .sda_oe(m_oe));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (stray_stop === 1'b1) strays <= strays + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic wait_ready(input int lim);
    for (n = 0; n < lim && ready !== 1'b1; n++) @(posedge clk_sys);
  endtask : wait_ready
  task automatic t_powerup();
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1 check(ready, 1'b0);
    wait_ready(60);
    check(n >= 20 && n < 60, 1'b1);
    $display("powerup done");
  endtask : t_powerup
  task automatic t_refuse();
    armed <= 1'b1;
    isl_master_model_inst.start_c();
    isl_master_model_inst.send_byte(8'h87, 1'b0, ack);
    check(ack, 1'b0);
    isl_master_model_inst.stop_c();
    armed <= 1'b0;
    isl_master_model_inst.start_c();
    isl_master_model_inst.send_byte(8'h86, 1'b0, ack);
    check(ack, 1'b0);
    check(asleep, 1'b0);
    isl_master_model_inst.stop_c();
    $display("refuse done");
  endtask : t_refuse
  task automatic t_float();
    armed <= 1'b1;
    isl_master_model_inst.start_c();
    isl_master_model_inst.send_byte(8'h86, 1'b0, ack);
    armed <= 1'b0;
    check(ack, 1'b1);
    check(asleep, 1'b1);
    check(sda_oe, 1'b0);
    check(sda_o, 1'b0);
    check(strays, 1);
    $display("float entry done");
  endtask : t_float
  task automatic t_wake();
    isl_master_model_inst.start_c();
    check(ready, 1'b0);
    check(asleep, 1'b0);
    wait_ready(400);
    check(n >= 240 && n <= 300, 1'b1);
    isl_master_model_inst.stop_c();
    $display("wake done");
  endtask : t_wake
  task automatic t_hold();
    armed <= 1'b1;
    isl_master_model_inst.start_c();
    isl_master_model_inst.send_byte(8'h86, 1'b1, ack);
    check(ack, 1'b1);
    check(asleep, 1'b1);
    check(strays, 1);
    check(sda_w, 1'b0);
    $display("held entry done");
  endtask : t_hold
  initial begin
    rst_b = 1'b0;
    armed = 1'b0;
    t_powerup();
    t_refuse();
    t_float();
    t_wake();
    t_hold();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule : isl_sleep_entry_test
